// *** shared/pfs_pkg.sv ***
// Purpose: constants and types for the port A low / port B pin function select
// Assumes: AXI4-Lite register access, 32-bit data
// Notes: register offsets are byte addresses

package pfs_pkg;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [3:0] PFS_OFS_PA_LOW = 4'h0;
  localparam logic [3:0] PFS_OFS_PB_HIGH = 4'h4;
  localparam logic [3:0] PFS_OFS_PB_LOW = 4'h8;
  localparam logic [3:0] PFS_OFS_PA_DIR = 4'hC;
  localparam logic [3:0] PFS_OFS_PB_DIR = 4'h0;
  localparam logic [4:0] PFS_OFS_PB_DIR_FULL = 5'h10;

  // ----------------------------------------
  // reset values and fixed bits
  // ----------------------------------------
  localparam logic [15:0] PFS_RST_PA_LOW = 16'hFF95;
  localparam logic [15:0] PFS_PA_LOW_WMASK = 16'h55FF;
  localparam logic [15:0] PFS_RST_PB = 16'h0000;
  localparam logic [15:0] PFS_RST_DIR = 16'h0000;

  // ----------------------------------------
  // field positions in port_a_low_pin_function
  // ----------------------------------------
  localparam int PFS_PA7_BIT = 14;
  localparam int PFS_PA6_BIT = 12;
  localparam int PFS_PA5_BIT = 10;
  localparam int PFS_PA4_BIT = 8;
  localparam int PFS_PA3_LSB = 6;
  localparam int PFS_PA2_LSB = 4;
  localparam int PFS_PA1_LSB = 2;
  localparam int PFS_PA0_LSB = 0;

  // ----------------------------------------
  // two-bit pin codes
  // ----------------------------------------
  typedef enum logic [1:0] {
    PFS_CODE_GPIO = 2'b00,
    PFS_CODE_ALT1 = 2'b01,
    PFS_CODE_ALT2 = 2'b10,
    PFS_CODE_ALT3 = 2'b11
  } pfs_code_e;

  localparam logic [1:0] PFS_RESP_OKAY = 2'b00;
  localparam logic [1:0] PFS_RESP_SLVERR = 2'b10;

  // peripheral signals that the mux routes onto port A low pins
  typedef struct packed {
    logic bus_grant_ack;
    logic read_strobe;
    logic upper_write_strobe;
    logic lower_write_strobe;
    logic chip_select_seven;
    logic chip_select_six;
    logic chip_select_five;
    logic chip_select_four;
    logic row_strobe;
  } pfs_bus_sig_s;

  // peripheral output pins: output value, plus output enable for the two-way pins
  typedef struct packed {
    logic timer0_capcmp_a_o;
    logic timer0_capcmp_a_oe;
    logic timer0_capcmp_b_o;
    logic timer0_capcmp_b_oe;
    logic serial0_clock_pin_o;
    logic serial0_clock_pin_oe;
    logic serial1_clock_pin_o;
    logic serial1_clock_pin_oe;
    logic serial0_transmit_pin;
    logic serial1_transmit_pin;
  } pfs_periph_out_s;

  // pin levels handed back to peripherals
  typedef struct packed {
    logic ext_wait;
    logic timer0_capcmp_a;
    logic timer0_capcmp_b;
    logic [7:4] ext_interrupt;
    logic serial0_clock_pin;
    logic serial1_clock_pin;
    logic serial0_receive_pin;
    logic serial1_receive_pin;
  } pfs_periph_in_s;

endpackage

// *** verilog/pfs_pin_mux.sv ***
// Purpose: pin function select for port A pins 7..0 and port B pins 15..0
// Assumes: AXI4-Lite slave, one clock, pin inputs synchronous to CLK
// Notes: pin outputs, enables and peripheral inputs are registered

`timescale 1ns/100ps

module pfs_pin_mux
  import pfs_pkg::*;
#(
  parameter int ADDR_W = 5
) (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic [ADDR_W-1:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [ADDR_W-1:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  input wire logic [7:0] PA_GPIO_OUT,
  input wire logic [15:0] PB_GPIO_OUT,
  input wire logic [15:0] PATTERN_OUT,
  input wire pfs_bus_sig_s BUS_SIG,
  input wire pfs_periph_out_s PERIPH_OUT,
  input wire logic [7:0] PA_PIN_IN,
  input wire logic [15:0] PB_PIN_IN,
  output logic [7:0] PA_PIN_OUT,
  output logic [7:0] PA_PIN_OE,
  output logic [15:0] PB_PIN_OUT,
  output logic [15:0] PB_PIN_OE,
  output logic [7:0] PA_GPIO_IN,
  output logic [15:0] PB_GPIO_IN,
  output pfs_periph_in_s PERIPH_IN
);

  // ----------------------------------------
  // elaboration checks
  // ----------------------------------------
  if (ADDR_W < 5 || ADDR_W > 16) begin : g_addr_chk
    $error("pfs_pin_mux: ADDR_W must be 5..16");
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // byte-lane merge
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                          input logic [3:0] st);
    logic [15:0] r;
    r = old;
    if (st[0]) begin
      r[7:0] = wd[7:0];
    end
    if (st[1]) begin
      r[15:8] = wd[15:8];
    end
    return r;
  endfunction

  function automatic logic [1:0] fld(input logic [15:0] r, input int lsb);
    return r[lsb +: 2];
  endfunction

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [15:0] pa_low_q;
  logic [15:0] pb_high_q;
  logic [15:0] pb_low_q;
  logic [15:0] pa_dir_q;
  logic [15:0] pb_dir_q;

  // ----------------------------------------
  // write channel
  // ----------------------------------------
  logic aw_held_q;
  logic w_held_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic do_write;
  logic [ADDR_W-1:0] wa;

  assign do_write = aw_held_q && w_held_q && !BVALID;
  assign wa = {awaddr_q[ADDR_W-1:2], 2'b00};

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      aw_held_q <= 1'b0;
      awaddr_q <= '0;
    end else if (AWVALID && AWREADY) begin
      aw_held_q <= 1'b1;
      awaddr_q <= AWADDR;
    end else if (do_write) begin
      aw_held_q <= 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      w_held_q <= 1'b0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else if (WVALID && WREADY) begin
      w_held_q <= 1'b1;
      wdata_q <= WDATA;
      wstrb_q <= WSTRB;
    end else if (do_write) begin
      w_held_q <= 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      AWREADY <= 1'b0;
      WREADY <= 1'b0;
    end else begin
      AWREADY <= !aw_held_q && !(AWVALID && AWREADY) && !do_write && !BVALID;
      WREADY <= !w_held_q && !(WVALID && WREADY) && !do_write && !BVALID;
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      BVALID <= 1'b0;
      BRESP <= PFS_RESP_OKAY;
    end else if (do_write) begin
      BVALID <= 1'b1;
      if (wa == ADDR_W'(PFS_OFS_PA_LOW) || wa == ADDR_W'(PFS_OFS_PB_HIGH) ||
          wa == ADDR_W'(PFS_OFS_PB_LOW) || wa == ADDR_W'(PFS_OFS_PA_DIR) ||
          wa == ADDR_W'(PFS_OFS_PB_DIR_FULL)) begin
        BRESP <= PFS_RESP_OKAY;
      end else begin
        BRESP <= PFS_RESP_SLVERR;
      end
    end else if (BVALID && BREADY) begin
      BVALID <= 1'b0;
    end
  end

  // ----------------------------------------
  // register writes
  // ----------------------------------------
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      pa_low_q <= PFS_RST_PA_LOW;
      pb_high_q <= PFS_RST_PB;
      pb_low_q <= PFS_RST_PB;
      pa_dir_q <= PFS_RST_DIR;
      pb_dir_q <= PFS_RST_DIR;
    end else if (do_write) begin
      if (wa == ADDR_W'(PFS_OFS_PA_LOW)) begin
        pa_low_q <= (merge16(pa_low_q, wdata_q, wstrb_q) & PFS_PA_LOW_WMASK) |
                    (PFS_RST_PA_LOW & ~PFS_PA_LOW_WMASK);
      end else if (wa == ADDR_W'(PFS_OFS_PB_HIGH)) begin
        pb_high_q <= merge16(pb_high_q, wdata_q, wstrb_q);
      end else if (wa == ADDR_W'(PFS_OFS_PB_LOW)) begin
        pb_low_q <= merge16(pb_low_q, wdata_q, wstrb_q);
      end else if (wa == ADDR_W'(PFS_OFS_PA_DIR)) begin
        pa_dir_q <= merge16(pa_dir_q, wdata_q, wstrb_q);
      end else if (wa == ADDR_W'(PFS_OFS_PB_DIR_FULL)) begin
        pb_dir_q <= merge16(pb_dir_q, wdata_q, wstrb_q);
      end
    end
  end

  // ----------------------------------------
  // read channel
  // ----------------------------------------
  logic [ADDR_W-1:0] ra;
  assign ra = {ARADDR[ADDR_W-1:2], 2'b00};

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      ARREADY <= 1'b0;
    end else begin
      ARREADY <= !RVALID && !(ARVALID && ARREADY);
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      RVALID <= 1'b0;
      RDATA <= '0;
      RRESP <= PFS_RESP_OKAY;
    end else if (ARVALID && ARREADY) begin
      RVALID <= 1'b1;
      RRESP <= PFS_RESP_OKAY;
      if (ra == ADDR_W'(PFS_OFS_PA_LOW)) begin
        RDATA <= {16'h0000, pa_low_q};
      end else if (ra == ADDR_W'(PFS_OFS_PB_HIGH)) begin
        RDATA <= {16'h0000, pb_high_q};
      end else if (ra == ADDR_W'(PFS_OFS_PB_LOW)) begin
        RDATA <= {16'h0000, pb_low_q};
      end else if (ra == ADDR_W'(PFS_OFS_PA_DIR)) begin
        RDATA <= {16'h0000, pa_dir_q};
      end else if (ra == ADDR_W'(PFS_OFS_PB_DIR_FULL)) begin
        RDATA <= {16'h0000, pb_dir_q};
      end else begin
        RDATA <= '0;
        RRESP <= PFS_RESP_SLVERR;
      end
    end else if (RVALID && RREADY) begin
      RVALID <= 1'b0;
    end
  end

  // ----------------------------------------
  // port A low pin mux
  // ----------------------------------------
  logic [7:0] pa_out_d;
  logic [7:0] pa_oe_d;

  always_comb begin
    pa_out_d = PA_GPIO_OUT;
    pa_oe_d = pa_dir_q[7:0];
    if (pa_low_q[PFS_PA7_BIT]) begin
      pa_out_d[7] = BUS_SIG.bus_grant_ack;
      pa_oe_d[7] = 1'b1;
    end
    if (pa_low_q[PFS_PA6_BIT]) begin
      pa_out_d[6] = BUS_SIG.read_strobe;
      pa_oe_d[6] = 1'b1;
    end
    if (pa_low_q[PFS_PA5_BIT]) begin
      pa_out_d[5] = BUS_SIG.upper_write_strobe;
      pa_oe_d[5] = 1'b1;
    end
    if (pa_low_q[PFS_PA4_BIT]) begin
      pa_out_d[4] = BUS_SIG.lower_write_strobe;
      pa_oe_d[4] = 1'b1;
    end
    // cs7 or wait; reserved idles as input
    case (fld(pa_low_q, PFS_PA3_LSB))
      PFS_CODE_GPIO: ;
      PFS_CODE_ALT1: begin
        pa_out_d[3] = BUS_SIG.chip_select_seven;
        pa_oe_d[3] = 1'b1;
      end
      default: pa_oe_d[3] = 1'b0;
    endcase
    case (fld(pa_low_q, PFS_PA2_LSB))
      PFS_CODE_GPIO: ;
      PFS_CODE_ALT1: begin
        pa_out_d[2] = BUS_SIG.chip_select_six;
        pa_oe_d[2] = 1'b1;
      end
      PFS_CODE_ALT2: begin
        pa_out_d[2] = PERIPH_OUT.timer0_capcmp_b_o;
        pa_oe_d[2] = PERIPH_OUT.timer0_capcmp_b_oe;
      end
      default: pa_oe_d[2] = 1'b0;
    endcase
    case (fld(pa_low_q, PFS_PA1_LSB))
      PFS_CODE_GPIO: ;
      PFS_CODE_ALT1: begin
        pa_out_d[1] = BUS_SIG.chip_select_five;
        pa_oe_d[1] = 1'b1;
      end
      PFS_CODE_ALT2: begin
        pa_out_d[1] = BUS_SIG.row_strobe;
        pa_oe_d[1] = 1'b1;
      end
      default: pa_oe_d[1] = 1'b0;
    endcase
    case (fld(pa_low_q, PFS_PA0_LSB))
      PFS_CODE_GPIO: ;
      PFS_CODE_ALT1: begin
        pa_out_d[0] = BUS_SIG.chip_select_four;
        pa_oe_d[0] = 1'b1;
      end
      PFS_CODE_ALT2: begin
        pa_out_d[0] = PERIPH_OUT.timer0_capcmp_a_o;
        pa_oe_d[0] = PERIPH_OUT.timer0_capcmp_a_oe;
      end
      default: pa_oe_d[0] = 1'b0;
    endcase
  end

  // ----------------------------------------
  // port B pin mux
  // ----------------------------------------
  logic [15:0] pb_out_d;
  logic [15:0] pb_oe_d;
  logic [31:0] pb_ctl;
  logic [1:0] c;
  assign pb_ctl = {pb_high_q, pb_low_q};

  always_comb begin
    pb_out_d = PB_GPIO_OUT;
    pb_oe_d = pb_dir_q;
    c = 2'b00;
    for (int i = 0; i < 16; i++) begin
      c = pb_ctl[2*i +: 2];
      if (c == PFS_CODE_ALT3) begin
        pb_out_d[i] = PATTERN_OUT[i];
        pb_oe_d[i] = 1'b1;
      end else if (c != PFS_CODE_GPIO) begin
        pb_oe_d[i] = 1'b0;
      end
    end
    if (pb_ctl[26 +: 2] == PFS_CODE_ALT2) begin
      pb_out_d[13] = PERIPH_OUT.serial1_clock_pin_o;
      pb_oe_d[13] = PERIPH_OUT.serial1_clock_pin_oe;
    end
    if (pb_ctl[24 +: 2] == PFS_CODE_ALT2) begin
      pb_out_d[12] = PERIPH_OUT.serial0_clock_pin_o;
      pb_oe_d[12] = PERIPH_OUT.serial0_clock_pin_oe;
    end
    if (pb_ctl[22 +: 2] == PFS_CODE_ALT2) begin
      pb_out_d[11] = PERIPH_OUT.serial1_transmit_pin;
      pb_oe_d[11] = 1'b1;
    end
    if (pb_ctl[18 +: 2] == PFS_CODE_ALT2) begin
      pb_out_d[9] = PERIPH_OUT.serial0_transmit_pin;
      pb_oe_d[9] = 1'b1;
    end
  end

  // ----------------------------------------
  // registered pins and peripheral inputs
  // ----------------------------------------
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      PA_PIN_OUT <= '0;
      PA_PIN_OE <= '0;
      PB_PIN_OUT <= '0;
      PB_PIN_OE <= '0;
    end else begin
      PA_PIN_OUT <= pa_out_d;
      PA_PIN_OE <= pa_oe_d;
      PB_PIN_OUT <= pb_out_d;
      PB_PIN_OE <= pb_oe_d;
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      PA_GPIO_IN <= '0;
      PB_GPIO_IN <= '0;
      PERIPH_IN <= '0;
    end else begin
      PA_GPIO_IN <= PA_PIN_IN;
      PB_GPIO_IN <= PB_PIN_IN;
      PERIPH_IN.ext_wait <= (fld(pa_low_q, PFS_PA3_LSB) == PFS_CODE_ALT2) ? PA_PIN_IN[3] : 1'b1;
      PERIPH_IN.timer0_capcmp_b <= (fld(pa_low_q, PFS_PA2_LSB) == PFS_CODE_ALT2) &&
                                   PA_PIN_IN[2];
      PERIPH_IN.timer0_capcmp_a <= (fld(pa_low_q, PFS_PA0_LSB) == PFS_CODE_ALT2) &&
                                   PA_PIN_IN[0];
      for (int k = 4; k < 8; k++) begin
        PERIPH_IN.ext_interrupt[k] <= (pb_ctl[2*(k+8) +: 2] == PFS_CODE_ALT1) ?
                                      PB_PIN_IN[k+8] : 1'b1;
      end
      PERIPH_IN.serial1_clock_pin <= (pb_ctl[26 +: 2] == PFS_CODE_ALT2) && PB_PIN_IN[13];
      PERIPH_IN.serial0_clock_pin <= (pb_ctl[24 +: 2] == PFS_CODE_ALT2) && PB_PIN_IN[12];
      PERIPH_IN.serial1_receive_pin <= (pb_ctl[20 +: 2] == PFS_CODE_ALT2) ? PB_PIN_IN[10] : 1'b1;
      PERIPH_IN.serial0_receive_pin <= (pb_ctl[16 +: 2] == PFS_CODE_ALT2) ? PB_PIN_IN[8] : 1'b1;
    end
  end

endmodule

// *** tb/pfs_pin_mux_properties.sv ***
// Purpose: bus and pin timing checks for pfs_pin_mux
// Assumes: one clock, async active-low reset
// Notes: sees top ports only; bound below

`timescale 1ns/100ps

module pfs_pin_mux_properties
  import pfs_pkg::*;
#(
  parameter int ADDR_W = 5
) (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic AWVALID,
  input wire logic AWREADY,
  input wire logic WVALID,
  input wire logic WREADY,
  input wire logic [1:0] BRESP,
  input wire logic BVALID,
  input wire logic BREADY,
  input wire logic [ADDR_W-1:0] ARADDR,
  input wire logic ARVALID,
  input wire logic ARREADY,
  input wire logic [31:0] RDATA,
  input wire logic [1:0] RRESP,
  input wire logic RVALID,
  input wire logic RREADY,
  input wire logic [7:0] PA_PIN_IN,
  input wire logic [15:0] PB_PIN_IN,
  input wire logic [7:0] PA_GPIO_IN,
  input wire logic [15:0] PB_GPIO_IN
);
  // ----------------------------------------
  // read address capture
  // ----------------------------------------
  logic [ADDR_W-1:0] rd_addr_q;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESETN);
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) rd_addr_q <= '0;
    else if (ARVALID && ARREADY) rd_addr_q <= ARADDR;
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_write_answer: assert property (AWVALID && AWREADY && WVALID && WREADY |=> ##[0:1] BVALID)
    else $error("write response missing");
  a_bvalid_holds: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
    else $error("write response dropped");
  a_write_refused: assert property (BVALID |-> !AWREADY && !WREADY)
    else $error("write taken while response pending");
  a_read_answer: assert property (ARVALID && ARREADY |=> ##[0:1] RVALID)
    else $error("read response missing");
  a_rvalid_holds: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
    else $error("read response dropped");
  a_read_refused: assert property (RVALID |-> !ARREADY)
    else $error("read taken while response pending");
  a_upper_zero: assert property (RVALID |-> RDATA[31:16] == 16'h0000)
    else $error("upper read half not zero");
  a_fixed_ones: assert property (RVALID && rd_addr_q[ADDR_W-1:2] == '0
    |-> (RDATA[15:0] & 16'hAA00) == 16'hAA00)
    else $error("fixed port A bits not one");
  a_unmapped_err: assert property (RVALID && rd_addr_q[ADDR_W-1:2] > (ADDR_W-2)'(4)
    |-> RRESP == PFS_RESP_SLVERR && RDATA == 32'h0000_0000)
    else $error("unmapped read not refused");
  a_gpio_sample: assert property ($past(RESETN)
    |-> PA_GPIO_IN == $past(PA_PIN_IN) && PB_GPIO_IN == $past(PB_PIN_IN))
    else $error("pin level not sampled");
endmodule

bind pfs_pin_mux pfs_pin_mux_properties #(.ADDR_W(ADDR_W)) u_props (.CLK, .RESETN, .AWVALID,
  .AWREADY, .WVALID, .WREADY, .BRESP, .BVALID, .BREADY, .ARADDR, .ARVALID, .ARREADY, .RDATA,
  .RRESP, .RVALID, .RREADY, .PA_PIN_IN, .PB_PIN_IN, .PA_GPIO_IN, .PB_GPIO_IN);

// *** tb/pfs_pin_mux_tb.sv ***
// Purpose: register and pin routing bench for pfs_pin_mux
// Assumes: AXI4-Lite master tasks, 100 ns clock
// Notes: every code of every field is set and checked at the pins

`timescale 1ns/100ps

`define CHK(nm, e, s) begin check_count++; if ((s) !== (e)) begin n_mismatch++; \
  $display("[ERR] %s exp %h got %h", nm, e, s); end end

module pfs_pin_mux_tb;
  import pfs_pkg::*;
  logic CLK, RESETN, AWVALID, WVALID, BREADY, ARVALID, RREADY;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID;
  logic [4:0] AWADDR, ARADDR;
  logic [31:0] WDATA, RDATA, pv, d;
  logic [3:0] WSTRB;
  logic [1:0] BRESP, RRESP, r, c;
  logic [7:0] PA_GPIO_OUT, PA_PIN_IN, PA_PIN_OUT, PA_PIN_OE, PA_GPIO_IN;
  logic [15:0] PB_GPIO_OUT, PATTERN_OUT, PB_PIN_IN, PB_PIN_OUT, PB_PIN_OE, PB_GPIO_IN, w;
  logic [15:0] m [5];
  pfs_bus_sig_s BUS_SIG;
  pfs_periph_out_s PERIPH_OUT;
  pfs_periph_in_s PERIPH_IN;
  int n_mismatch = 0;
  int check_count = 0;

  pfs_pin_mux #(.ADDR_W(5)) dut (.CLK, .RESETN, .AWADDR, .AWVALID, .AWREADY, .WDATA, .WSTRB,
    .WVALID, .WREADY, .BRESP, .BVALID, .BREADY, .ARADDR, .ARVALID, .ARREADY, .RDATA, .RRESP,
    .RVALID, .RREADY, .PA_GPIO_OUT, .PB_GPIO_OUT, .PATTERN_OUT, .BUS_SIG, .PERIPH_OUT,
    .PA_PIN_IN, .PB_PIN_IN, .PA_PIN_OUT, .PA_PIN_OE, .PB_PIN_OUT, .PB_PIN_OE, .PA_GPIO_IN,
    .PB_GPIO_IN, .PERIPH_IN);

  initial CLK = 1'b0;
  always #50 CLK = ~CLK;

  // ----------------------------------------
  // bus tasks
  // ----------------------------------------
  task automatic wr(input logic [4:0] a, input logic [31:0] dd, input logic [3:0] s);
    @(posedge CLK);
    AWADDR <= a;
    WDATA <= dd;
    WSTRB <= s;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    do begin
      @(posedge CLK);
      if (AWREADY) AWVALID <= 1'b0;
      if (WREADY) WVALID <= 1'b0;
    end while (BVALID !== 1'b1);
    r = BRESP;
    BREADY <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] a);
    @(posedge CLK);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    do begin
      @(posedge CLK);
      if (ARREADY) ARVALID <= 1'b0;
    end while (RVALID !== 1'b1);
    d = RDATA;
    r = RRESP;
    RREADY <= 1'b0;
  endtask

  task automatic wok(input logic [4:0] a, input logic [31:0] dd, input logic [3:0] s);
    wr(a, dd, s);
    `CHK("bresp", PFS_RESP_OKAY, r)
  endtask

  task automatic rdall;
    for (int i = 0; i < 5; i++) begin
      rd(5'(i * 4));
      `CHK("rresp", PFS_RESP_OKAY, r)
      `CHK("reg", {16'h0000, m[i]}, d)
    end
  endtask

  task automatic do_reset;
    RESETN <= 1'b0;
    repeat (4) @(posedge CLK);
    RESETN <= 1'b1;
    repeat (2) @(posedge CLK);
    m[0] = PFS_RST_PA_LOW;
    m[1] = PFS_RST_PB;
    m[2] = PFS_RST_PB;
    m[3] = PFS_RST_DIR;
    m[4] = PFS_RST_DIR;
  endtask

  // ----------------------------------------
  // expected pin routing
  // ----------------------------------------
  task automatic chk_pins;
    logic [7:0] ao, ae;
    logic [15:0] bo, be;
    logic [1:0] k;
    pfs_periph_in_s pi;
    ao = PA_GPIO_OUT;
    ae = m[3][7:0];
    bo = PB_GPIO_OUT;
    be = m[4];
    pi = '0;
    pi.ext_wait = 1'b1;
    pi.ext_interrupt = 4'hF;
    pi.serial0_receive_pin = 1'b1;
    pi.serial1_receive_pin = 1'b1;
    if (m[0][14]) {ae[7], ao[7]} = {1'b1, BUS_SIG.bus_grant_ack};
    if (m[0][12]) {ae[6], ao[6]} = {1'b1, BUS_SIG.read_strobe};
    if (m[0][10]) {ae[5], ao[5]} = {1'b1, BUS_SIG.upper_write_strobe};
    if (m[0][8]) {ae[4], ao[4]} = {1'b1, BUS_SIG.lower_write_strobe};
    if (m[0][7:6] == 2'b01) {ae[3], ao[3]} = {1'b1, BUS_SIG.chip_select_seven};
    if (m[0][7:6] == 2'b10) pi.ext_wait = PA_PIN_IN[3];
    if (m[0][7]) ae[3] = 1'b0;
    if (m[0][5:4] == 2'b01) {ae[2], ao[2]} = {1'b1, BUS_SIG.chip_select_six};
    if (m[0][5:4] == 2'b10) begin
      {ae[2], ao[2]} = {PERIPH_OUT.timer0_capcmp_b_oe, PERIPH_OUT.timer0_capcmp_b_o};
      pi.timer0_capcmp_b = PA_PIN_IN[2];
    end
    if (m[0][5:4] == 2'b11) ae[2] = 1'b0;
    if (m[0][3:2] == 2'b01) {ae[1], ao[1]} = {1'b1, BUS_SIG.chip_select_five};
    if (m[0][3:2] == 2'b10) {ae[1], ao[1]} = {1'b1, BUS_SIG.row_strobe};
    if (m[0][3:2] == 2'b11) ae[1] = 1'b0;
    if (m[0][1:0] == 2'b01) {ae[0], ao[0]} = {1'b1, BUS_SIG.chip_select_four};
    if (m[0][1:0] == 2'b10) begin
      {ae[0], ao[0]} = {PERIPH_OUT.timer0_capcmp_a_oe, PERIPH_OUT.timer0_capcmp_a_o};
      pi.timer0_capcmp_a = PA_PIN_IN[0];
    end
    if (m[0][1:0] == 2'b11) ae[0] = 1'b0;
    for (int i = 0; i < 16; i++) begin
      k = (i < 8) ? m[2][2*i +: 2] : m[1][2*i-16 +: 2];
      if (k == 2'b11) {be[i], bo[i]} = {1'b1, PATTERN_OUT[i]};
      else if (k != 2'b00) be[i] = 1'b0;
      if (i > 11 && k == 2'b01) pi.ext_interrupt[i-8] = PB_PIN_IN[i];
    end
    if (m[1][11:10] == 2'b10) begin
      {be[13], bo[13]} = {PERIPH_OUT.serial1_clock_pin_oe, PERIPH_OUT.serial1_clock_pin_o};
      pi.serial1_clock_pin = PB_PIN_IN[13];
    end
    if (m[1][9:8] == 2'b10) begin
      {be[12], bo[12]} = {PERIPH_OUT.serial0_clock_pin_oe, PERIPH_OUT.serial0_clock_pin_o};
      pi.serial0_clock_pin = PB_PIN_IN[12];
    end
    if (m[1][7:6] == 2'b10) {be[11], bo[11]} = {1'b1, PERIPH_OUT.serial1_transmit_pin};
    if (m[1][5:4] == 2'b10) pi.serial1_receive_pin = PB_PIN_IN[10];
    if (m[1][3:2] == 2'b10) {be[9], bo[9]} = {1'b1, PERIPH_OUT.serial0_transmit_pin};
    if (m[1][1:0] == 2'b10) pi.serial0_receive_pin = PB_PIN_IN[8];
    `CHK("pa_oe", ae, PA_PIN_OE)
    `CHK("pa_out", ao & ae, PA_PIN_OUT & ae)
    `CHK("pb_oe", be, PB_PIN_OE)
    `CHK("pb_out", bo & be, PB_PIN_OUT & be)
    `CHK("periph_in", pi, PERIPH_IN)
    `CHK("gpio_in", {PA_PIN_IN, PB_PIN_IN}, {PA_GPIO_IN, PB_GPIO_IN})
  endtask

  task automatic summarize;
    $display("mismatches %0d of %0d checks", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    {RESETN, AWVALID, WVALID, BREADY, ARVALID, RREADY, AWADDR, ARADDR, WDATA, WSTRB} = '0;
    {PA_GPIO_OUT, PB_GPIO_OUT, PATTERN_OUT, BUS_SIG, PERIPH_OUT, PA_PIN_IN, PB_PIN_IN} = '0;
    do_reset;
    rdall;
    chk_pins;
    for (int p = 0; p < 2; p++) begin
      pv = p ? 32'hC3A5_5A3C : 32'h3C5A_A5C3;
      PA_GPIO_OUT <= pv[7:0];
      PB_GPIO_OUT <= pv[15:0];
      PATTERN_OUT <= pv[27:12];
      BUS_SIG <= pfs_bus_sig_s'(pv[12:4]);
      PERIPH_OUT <= pfs_periph_out_s'(pv[19:10]);
      PA_PIN_IN <= pv[23:16];
      PB_PIN_IN <= pv[31:16];
      for (int k = 0; k < 4; k++) begin
        c = k[1:0];
        w = {{4{1'b0, c[0]}}, {4{c}}};
        wok(5'h00, {16'hFFFF, w}, 4'hF);
        m[0] = (w & PFS_PA_LOW_WMASK) | ~PFS_PA_LOW_WMASK;
        m[1] = {8{c}};
        m[2] = {8{~c}};
        m[3] = pv[15:0];
        m[4] = ~pv[15:0];
        wok(5'h04, {16'h0000, m[1]}, 4'hF);
        wok(5'h08, {16'h0000, m[2]}, 4'hF);
        wok(5'h0C, {16'h0000, m[3]}, 4'hF);
        wok(5'h10, {16'h0000, m[4]}, 4'hF);
        repeat (3) @(posedge CLK);
        chk_pins;
        rdall;
      end
    end
    wok(5'h04, 32'hFFFF_FFFF, 4'b0001);
    m[1][7:0] = 8'hFF;
    wok(5'h04, 32'h0000_0000, 4'b1100);
    wok(5'h08, 32'h0000_AB00, 4'b0010);
    m[2][15:8] = 8'hAB;
    rdall;
    wr(5'h14, 32'hFFFF_FFFF, 4'hF);
    `CHK("bresp_unmapped", PFS_RESP_SLVERR, r)
    rd(5'h14);
    `CHK("rresp_unmapped", PFS_RESP_SLVERR, r)
    `CHK("rdata_unmapped", 32'h0000_0000, d)
    rdall;
    do_reset;
    rdall;
    repeat (3) @(posedge CLK);
    chk_pins;
    summarize;
  end

  initial begin
    #2000000;
    n_mismatch++;
    summarize;
  end
endmodule
